// >>> sim/rsc_top_tb.sv
// Self-checking testbench for the receiver strength and capacitive sensor register block.
`timescale 1ns/1ps
`default_nettype none
module rsc_top_tb;
    import rsc_pkg::*;
    // Stimulus driven into the design, all given a value at time zero.
    logic CLK_SYS = 1'b0;
    logic RST = 1'b1;
    logic CYC_I = 1'b0, STB_I = 1'b0, WE_I = 1'b0, LEVEL_VALID = 1'b0, RX_MSG_START = 1'b0;
    logic [7:0] ADR_I = 8'h00;
    logic [3:0] SEL_I = 4'h0, AMP_LEVEL_CODE = 4'h0, PHASE_LEVEL_CODE = 4'h0;
    logic [3:0] AMP_GAIN_CUT_IN = 4'h0, PHASE_GAIN_CUT_IN = 4'h0;
    logic [31:0] DAT_I = 32'h0000_0000;
    // Outputs of the design.
    logic [31:0] DAT_O;
    logic ACK_O, CHANNEL_SELECT, SENSOR_AUTO_CAL;
    logic [3:0] STRENGTH_SELECTED;
    logic [4:0] SENSOR_MANUAL_TRIM;
    logic [2:0] SENSOR_GAIN_SELECT;
    // Reference peaks, random state and score counters.
    logic [3:0] pa = 4'h0, pp = 4'h0;
    logic [31:0] seed = 32'h0000_0026;
    logic [31:0] r, dd;
    logic [2:0] gcodes [5] = '{RSC_GAIN_2V8, RSC_GAIN_6V5, RSC_GAIN_1V1, RSC_GAIN_0V5, RSC_GAIN_0V35};
    int num_errors = 0, num_checks = 0;

    rsc_top i_rsc_top (.CLK_SYS(CLK_SYS), .RST(RST), .CYC_I(CYC_I), .STB_I(STB_I), .WE_I(WE_I), .ADR_I(ADR_I),
        .SEL_I(SEL_I), .DAT_I(DAT_I), .DAT_O(DAT_O), .ACK_O(ACK_O), .LEVEL_VALID(LEVEL_VALID),
        .AMP_LEVEL_CODE(AMP_LEVEL_CODE), .PHASE_LEVEL_CODE(PHASE_LEVEL_CODE), .RX_MSG_START(RX_MSG_START),
        .AMP_GAIN_CUT_IN(AMP_GAIN_CUT_IN), .PHASE_GAIN_CUT_IN(PHASE_GAIN_CUT_IN),
        .STRENGTH_SELECTED(STRENGTH_SELECTED), .CHANNEL_SELECT(CHANNEL_SELECT),
        .SENSOR_MANUAL_TRIM(SENSOR_MANUAL_TRIM), .SENSOR_GAIN_SELECT(SENSOR_GAIN_SELECT),
        .SENSOR_AUTO_CAL(SENSOR_AUTO_CAL));

    // The 200 MHz system clock.
    initial begin
        forever #2.5 CLK_SYS = ~CLK_SYS;
    end

    // Xorshift generator; the fixed start value makes every run alike.
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // Codes above the top of the scale are expected to read as the top code.
    function automatic logic [3:0] clamp(input logic [3:0] c);
        return (c > RSC_CODE_MAX) ? RSC_CODE_MAX : c;
    endfunction

    // Compares one value and reports a difference at once.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // One classic Wishbone cycle; request held until the edge that sees ack high.
    task automatic wb(input logic we, input logic [7:0] adr, input logic [7:0] wd, input logic [3:0] sel,
                      output logic [31:0] rd);
        @(posedge CLK_SYS);
        CYC_I <= 1'b1;
        STB_I <= 1'b1;
        WE_I <= we;
        ADR_I <= adr;
        SEL_I <= sel;
        DAT_I <= {24'h00_0000, wd};
        // Ack and read data are taken at a rising edge; only the watchdog ends a wait.
        @(posedge CLK_SYS);
        while (ACK_O !== 1'b1) begin
            @(posedge CLK_SYS);
        end
        rd = DAT_O;
        CYC_I <= 1'b0;
        STB_I <= 1'b0;
        WE_I <= 1'b0;
    endtask

    // Register write with all byte lanes enabled.
    task automatic wr(input logic [7:0] adr, input logic [7:0] wd);
        logic [31:0] d;
        wb(1'b1, adr, wd, 4'hF, d);
    endtask

    // Register read compared against the expected byte.
    task automatic rd_chk(input logic [7:0] adr, input logic [7:0] exp, input string what);
        logic [31:0] d;
        wb(1'b0, adr, 8'h00, 4'hF, d);
        chk(d, {24'h00_0000, exp}, what);
    endtask

    // Compares the sensor and channel pins once registered outputs have settled.
    task automatic chk_pins(input logic [4:0] trim, input logic [2:0] g, input logic cs);
        repeat (2) @(negedge CLK_SYS);
        chk({22'h0, CHANNEL_SELECT, SENSOR_AUTO_CAL, SENSOR_GAIN_SELECT, SENSOR_MANUAL_TRIM},
            {22'h0, cs, (trim == 5'h00), g, trim}, "sensor pins");
    endtask

    // One measurement cycle, optionally together with a message start.
    task automatic pulse(input logic rx, input logic v, input logic [3:0] a, input logic [3:0] p);
        @(posedge CLK_SYS);
        RX_MSG_START <= rx;
        LEVEL_VALID <= v;
        AMP_LEVEL_CODE <= a;
        PHASE_LEVEL_CODE <= p;
        if (rx) {pa, pp} = 8'h00;
        if (v && clamp(a) > pa) pa = clamp(a);
        if (v && clamp(p) > pp) pp = clamp(p);
        @(posedge CLK_SYS);
        RX_MSG_START <= 1'b0;
        LEVEL_VALID <= 1'b0;
    endtask

    // Burst of random measurements, one every second cycle with random gaps.
    task automatic meas(input int n);
        logic [31:0] x;
        repeat (n) begin
            x = xs();
            pulse(1'b0, x[8], x[3:0], x[7:4]);
        end
    endtask

    // Ends the run with the counts and the verdict.
    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    // Watchdog against a hung handshake; the tests need a few hundred cycles.
    initial begin
        repeat (20000) @(posedge CLK_SYS);
        num_errors++;
        conclude();
    end

    // Main sequence.
    initial begin
        repeat (8) @(posedge CLK_SYS);
        RST <= 1'b0;
        chk_pins(5'h00, 3'h0, 1'b0);
        rd_chk(8'h80, RSC_RESET_BYTE, "strength after reset");
        rd_chk(8'hB4, RSC_RESET_BYTE, "gain after reset");
        rd_chk(8'hB8, RSC_RESET_BYTE, "sensor after reset");
        $display("test reset done");
        // Peak hold with random codes, then clears and the top-code corner.
        meas(60);
        rd_chk(8'h80, {pa, pp}, "random peaks");
        pulse(1'b1, 1'b0, 4'h0, 4'h0);
        rd_chk(8'h80, 8'h00, "message start clear");
        pulse(1'b1, 1'b1, 4'hF, 4'hE);
        rd_chk(8'h80, {pa, pp}, "code in clear cycle");
        pulse(1'b1, 1'b1, 4'h3, 4'h9);
        rd_chk(8'h80, {pa, pp}, "clear with new code");
        pulse(1'b0, 1'b1, 4'h2, 4'h1);
        rd_chk(8'h80, {pa, pp}, "smaller code kept out");
        wr({RSC_IDX_CMD, 2'b00}, 8'h02);
        {pa, pp} = 8'h00;
        rd_chk(8'h80, 8'h00, "clear command");
        $display("test peaks done");
        // Channel select steers the internally used strength.
        for (int cs = 0; cs < 2; cs++) begin
            meas(20);
            wr(8'hC0, {cs[0], 7'h00});
            repeat (3) @(negedge CLK_SYS);
            chk({28'h0, STRENGTH_SELECTED}, {28'h0, cs[0] ? pp : pa}, "selected strength");
            chk({31'h0, CHANNEL_SELECT}, {31'h0, cs[0]}, "channel select pin");
        end
        $display("test channel done");
        // Gain reduction display follows the live inputs.
        repeat (8) begin
            r = xs();
            @(posedge CLK_SYS);
            AMP_GAIN_CUT_IN <= r[3:0];
            PHASE_GAIN_CUT_IN <= r[7:4];
            rd_chk(8'hB4, {r[3:0], r[7:4]}, "gain display");
        end
        $display("test gain done");
        // Every legal sensor gain code with a random trim, zero trim first.
        for (int i = 0; i < 5; i++) begin
            r = (i == 0) ? 32'h0000_0000 : xs();
            wr(8'hB8, {r[4:0], gcodes[i]});
            chk_pins(r[4:0], gcodes[i], 1'b1);
            rd_chk(8'hB8, {r[4:0], gcodes[i]}, "sensor readback");
        end
        $display("test sensor done");
        // Writes to read-only, unmapped and lane-disabled places change nothing.
        wr(8'h80, 8'hFF);
        wr(8'hB4, 8'hFF);
        wr(8'h04, 8'hFF);
        wb(1'b1, 8'hB8, 8'h00, 4'h0, dd);
        rd_chk(8'h80, {pa, pp}, "strength after write");
        rd_chk(8'hB4, {AMP_GAIN_CUT_IN, PHASE_GAIN_CUT_IN}, "gain after write");
        rd_chk(8'h04, 8'h00, "unmapped read");
        rd_chk(8'hB8, {r[4:0], gcodes[4]}, "sensor with lane off");
        $display("test read-only done");
        // Set-default command returns peaks, sensor fields and channel select to zero.
        meas(10);
        wr({RSC_IDX_CMD, 2'b00}, 8'h01);
        chk_pins(5'h00, 3'h0, 1'b0);
        rd_chk(8'h80, RSC_RESET_BYTE, "strength after default");
        rd_chk(8'hB8, RSC_RESET_BYTE, "sensor after default");
        $display("test default done");
        conclude();
    end
endmodule // rsc_top_tb
`default_nettype wire

// >>> verilog/rsc_peak_hold.sv
// Peak holder for one receive channel strength code.
`timescale 1ns/1ps
`default_nettype none
module rsc_peak_hold #(
    parameter int CODE_W = 4
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // Measurement stream and clear.
    input wire logic meas_valid,
    input wire logic [CODE_W-1:0] meas_code,
    input wire logic clear,
    // Held peak.
    output logic [CODE_W-1:0] peak
);
    import rsc_pkg::*;

    // The top and reset codes are four bits wide, so the width is fixed.
    initial begin
        if (CODE_W != 4) begin
            $error("rsc_peak_hold supports CODE_W of 4 only");
        end
    end

    // All state of the holder.
    typedef struct packed {
        logic [CODE_W-1:0] peak;
    } rsc_peak_state_t;

    rsc_peak_state_t st_q; // Registered state.
    rsc_peak_state_t st_d; // Next state.
    logic [CODE_W-1:0] code_lim; // Measurement limited to the top code.

    // Limits the code, then keeps the larger value; a clear restarts the hold.
    always_comb begin
        st_d = st_q;
        code_lim = (meas_code > RSC_CODE_MAX) ? RSC_CODE_MAX : meas_code;
        if (clear) begin
            // A measurement in the clear cycle is the first of the new message.
            st_d.peak = meas_valid ? code_lim : RSC_RESET_CODE;
        end else if (meas_valid && (code_lim > st_q.peak)) begin
            st_d.peak = code_lim;
        end
    end

    // Registers the state.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign peak = st_q.peak;
endmodule // rsc_peak_hold
`default_nettype wire

// >>> verilog/rsc_pkg.sv
// Package with register map, field layout and reset values of the receiver-strength and sensor registers.
package rsc_pkg;
    // Register indices; the Wishbone byte address is four times the index.
    localparam logic [5:0] RSC_IDX_STRENGTH = 6'h20;
    localparam logic [5:0] RSC_IDX_GAIN = 6'h2D;
    localparam logic [5:0] RSC_IDX_CAP = 6'h2E;
    localparam logic [5:0] RSC_IDX_CHSEL = 6'h30;
    localparam logic [5:0] RSC_IDX_CMD = 6'h3E;
    // Address slice that carries the index inside a byte address.
    localparam int RSC_ADR_LSB = 2;
    localparam int RSC_ADR_MSB = 7;
    // Field positions inside the strength and gain registers.
    localparam int RSC_AMP_MSB = 7;
    localparam int RSC_AMP_LSB = 4;
    localparam int RSC_PH_MSB = 3;
    localparam int RSC_PH_LSB = 0;
    // Field positions inside the sensor control register.
    localparam int RSC_TRIM_MSB = 7;
    localparam int RSC_TRIM_LSB = 3;
    localparam int RSC_GSEL_MSB = 2;
    localparam int RSC_GSEL_LSB = 0;
    // Channel select bit inside the channel select register.
    localparam int RSC_CHSEL_BIT = 7;
    // Command bits inside the command register.
    localparam int RSC_CMD_DEFAULT_BIT = 0;
    localparam int RSC_CMD_CLEAR_BIT = 1;
    // Values after power-up and after the set-default command.
    localparam logic [7:0] RSC_RESET_BYTE = 8'h00;
    localparam logic [3:0] RSC_RESET_CODE = 4'h0;
    localparam logic [4:0] RSC_RESET_TRIM = 5'h00;
    localparam logic [2:0] RSC_RESET_GSEL = 3'h0;
    // Highest strength code that is ever produced.
    localparam logic [3:0] RSC_CODE_MAX = 4'hD;
    // Sensor gain codes that software may write.
    localparam logic [2:0] RSC_GAIN_2V8 = 3'h0;
    localparam logic [2:0] RSC_GAIN_6V5 = 3'h1;
    localparam logic [2:0] RSC_GAIN_1V1 = 3'h2;
    localparam logic [2:0] RSC_GAIN_0V5 = 3'h4;
    localparam logic [2:0] RSC_GAIN_0V35 = 3'h6;
    // Unused upper bits of the 32-bit read data.
    localparam logic [23:0] RSC_DAT_PAD = 24'h00_0000;
endpackage

// >>> verilog/rsc_top.sv
// Receiver strength, gain state and capacitive sensor registers behind a Wishbone slave.
// Function
// - Amplitude peak code held in bits 7:4.
// - Phase peak code held in bits 3:0.
// - Peaks clear on message start and command.
// - Codes are logarithmic, never above thirteen.
// - Channel select bit picks strength used internally.
// - Gain bits 7:4 show amplitude gain cut.
// - Gain bits 3:0 show phase gain cut.
// - Sensor bits 7:3 hold manual trim.
// - Zero trim selects automatic calibration.
// - Sensor bits 2:0 select gain, legal codes only; any code written is stored.
// - Reset and set-default load all zeros, except automatic calibration, which turns on.
//
// Chosen here: the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
module rsc_top #(
    parameter int CODE_W = 4
) (
    // Clock and reset.
    input wire logic CLK_SYS,
    input wire logic RST,
    // Wishbone classic slave.
    input wire logic CYC_I,
    input wire logic STB_I,
    input wire logic WE_I,
    input wire logic [7:0] ADR_I,
    input wire logic [3:0] SEL_I,
    input wire logic [31:0] DAT_I,
    output logic [31:0] DAT_O,
    output logic ACK_O,
    // Measurement side.
    input wire logic LEVEL_VALID,
    input wire logic [3:0] AMP_LEVEL_CODE,
    input wire logic [3:0] PHASE_LEVEL_CODE,
    input wire logic RX_MSG_START,
    input wire logic [3:0] AMP_GAIN_CUT_IN,
    input wire logic [3:0] PHASE_GAIN_CUT_IN,
    // Outputs to the receiver and sensor logic.
    output logic [3:0] STRENGTH_SELECTED,
    output logic CHANNEL_SELECT,
    output logic [4:0] SENSOR_MANUAL_TRIM,
    output logic [2:0] SENSOR_GAIN_SELECT,
    output logic SENSOR_AUTO_CAL
);
    import rsc_pkg::*;

    // Field widths follow the register layout, so only four bits are served.
    initial begin
        if (CODE_W != 4) begin
            $error("rsc_top supports CODE_W of 4 only");
        end
    end

    // All state of the register bank.
    typedef struct packed {
        logic ack;
        logic [7:0] rdat;
        logic [3:0] amp_gain;
        logic [3:0] ph_gain;
        logic [4:0] trim;
        logic [2:0] gsel;
        logic chsel;
        logic [3:0] sel_strength;
        logic auto_cal;
    } rsc_state_t;

    rsc_state_t st_q; // Registered state.
    rsc_state_t st_d; // Next state.

    logic [3:0] amp_channel_peak_strength; // Held amplitude peak.
    logic [3:0] phase_channel_peak_strength; // Held phase peak.
    logic [5:0] idx; // Register index of the request.
    logic req; // A bus request waits for its answer.
    logic wr_now; // A write takes effect at this edge.
    logic cmd_default; // Set-default command at this edge.
    logic cmd_clear; // Clear-strength command at this edge.
    logic peak_clear; // Clear for both peak holders.
    logic [3:0] sel_src; // Strength chosen by the channel select bit.

    // Decodes the request; writes act on the edge at which the master sees ack.
    always_comb begin
        idx = ADR_I[RSC_ADR_MSB:RSC_ADR_LSB];
        req = CYC_I && STB_I;
        wr_now = req && WE_I && st_q.ack && SEL_I[0];
        cmd_default = wr_now && (idx == RSC_IDX_CMD) && DAT_I[RSC_CMD_DEFAULT_BIT];
        cmd_clear = wr_now && (idx == RSC_IDX_CMD) && DAT_I[RSC_CMD_CLEAR_BIT];
        // Set-default also empties the peaks.
        peak_clear = RX_MSG_START || cmd_clear || cmd_default;
        sel_src = st_q.chsel ? phase_channel_peak_strength : amp_channel_peak_strength;
    end

    // Amplitude channel peak holder.
    rsc_peak_hold #(
        .CODE_W(CODE_W)
    ) u_amp_peak (
        .clk(CLK_SYS),
        .rst(RST),
        .meas_valid(LEVEL_VALID),
        .meas_code(AMP_LEVEL_CODE),
        .clear(peak_clear),
        .peak(amp_channel_peak_strength)
    );

    // Phase channel peak holder.
    rsc_peak_hold #(
        .CODE_W(CODE_W)
    ) u_phase_peak (
        .clk(CLK_SYS),
        .rst(RST),
        .meas_valid(LEVEL_VALID),
        .meas_code(PHASE_LEVEL_CODE),
        .clear(peak_clear),
        .peak(phase_channel_peak_strength)
    );

    // Computes the next state of the bus answer and of every register.
    always_comb begin
        st_d = st_q;
        // Ack rises one cycle after the request and falls the cycle after.
        st_d.ack = req && !st_q.ack;
        if (req && !st_q.ack) begin
            // Read data is captured together with the rising ack.
            unique case (idx)
                RSC_IDX_STRENGTH: begin
                    st_d.rdat = {amp_channel_peak_strength, phase_channel_peak_strength};
                end
                RSC_IDX_GAIN: begin
                    st_d.rdat = {st_q.amp_gain, st_q.ph_gain};
                end
                RSC_IDX_CAP: begin
                    st_d.rdat = {st_q.trim, st_q.gsel};
                end
                RSC_IDX_CHSEL: begin
                    st_d.rdat = {st_q.chsel, 7'h00};
                end
                default: begin
                    // Unmapped indices and the command register read as zero.
                    st_d.rdat = RSC_RESET_BYTE;
                end
            endcase
        end
        // The gain display follows the receiver every cycle except a set-default one.
        st_d.amp_gain = AMP_GAIN_CUT_IN;
        st_d.ph_gain = PHASE_GAIN_CUT_IN;
        // Only the sensor and channel select registers take writes.
        if (wr_now && (idx == RSC_IDX_CAP)) begin
            st_d.trim = DAT_I[RSC_TRIM_MSB:RSC_TRIM_LSB];
            // Software keeps to the five legal gain codes.
            st_d.gsel = DAT_I[RSC_GSEL_MSB:RSC_GSEL_LSB];
        end
        if (wr_now && (idx == RSC_IDX_CHSEL)) begin
            st_d.chsel = DAT_I[RSC_CHSEL_BIT];
        end
        // Writes to the strength and gain indices change nothing.
        if (cmd_default) begin
            // Set-default returns the sensor, channel select and gain fields to zero.
            st_d.trim = RSC_RESET_TRIM;
            st_d.gsel = RSC_RESET_GSEL;
            st_d.chsel = 1'b0;
            st_d.amp_gain = RSC_RESET_CODE;
            st_d.ph_gain = RSC_RESET_CODE;
        end
        // The selected strength and the calibration mode are registered outputs.
        st_d.sel_strength = sel_src;
        st_d.auto_cal = (st_d.trim == RSC_RESET_TRIM);
    end

    // Registers the state; reset loads all defaults and automatic calibration.
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            st_q <= '0;
            st_q.auto_cal <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    // Outputs come straight from the state flip-flops.
    assign DAT_O = {RSC_DAT_PAD, st_q.rdat};
    assign ACK_O = st_q.ack;
    assign STRENGTH_SELECTED = st_q.sel_strength;
    assign CHANNEL_SELECT = st_q.chsel;
    assign SENSOR_MANUAL_TRIM = st_q.trim;
    assign SENSOR_GAIN_SELECT = st_q.gsel;
    assign SENSOR_AUTO_CAL = st_q.auto_cal;

    // Checks below share the system clock and reset.
    default clocking rsc_cb @(posedge CLK_SYS);
    endclocking
    default disable iff (RST);

    // A fresh request followed by its single answer.
    sequence rsc_seq_req;
        req && !ACK_O;
    endsequence
    sequence rsc_seq_answer;
        ACK_O ##1 !ACK_O;
    endsequence

    // A write to the sensor register lands at the ack edge.
    sequence rsc_seq_cap_write;
        req && WE_I && SEL_I[0] && ACK_O && (idx == RSC_IDX_CAP);
    endsequence

    // The amplitude peak never falls without a clear.
    AST_AMP_PEAK_HOLD: assert property (!peak_clear |=> amp_channel_peak_strength >= $past(amp_channel_peak_strength))
        else $error("Amplitude peak fell without a clear.");

    // A larger phase code is taken into the peak.
    AST_PH_PEAK_LOAD: assert property (LEVEL_VALID && !peak_clear && (PHASE_LEVEL_CODE <= RSC_CODE_MAX)
        && (PHASE_LEVEL_CODE > phase_channel_peak_strength) |=> phase_channel_peak_strength == $past(PHASE_LEVEL_CODE))
        else $error("Phase peak missed a larger code.");

    // A clear with no measurement empties both peaks.
    AST_PEAK_CLEAR: assert property (peak_clear && !LEVEL_VALID
        |=> (amp_channel_peak_strength == RSC_RESET_CODE) && (phase_channel_peak_strength == RSC_RESET_CODE))
        else $error("Peaks not cleared.");

    // No amplitude or selected strength code above thirteen appears.
    AST_CODE_LIMIT: assert property ((amp_channel_peak_strength <= RSC_CODE_MAX) && (STRENGTH_SELECTED <= RSC_CODE_MAX))
        else $error("Strength code above the top code.");

    // The selected strength follows the channel select one cycle later.
    AST_SELECT_PATH: assert property (1'b1 |=> STRENGTH_SELECTED == $past(sel_src))
        else $error("Selected strength does not follow the channel select.");

    // The amplitude gain display follows the receiver.
    AST_AMP_GAIN: assert property (!cmd_default |=> st_q.amp_gain == $past(AMP_GAIN_CUT_IN))
        else $error("Amplitude gain display stale.");

    // The phase gain display follows the receiver.
    AST_PH_GAIN: assert property (!cmd_default |=> st_q.ph_gain == $past(PHASE_GAIN_CUT_IN))
        else $error("Phase gain display stale.");

    // A sensor write stores the trim and gain fields.
    AST_TRIM_WRITE: assert property (rsc_seq_cap_write |=> (SENSOR_MANUAL_TRIM == $past(DAT_I[7:3]))
        && (SENSOR_GAIN_SELECT == $past(DAT_I[2:0])))
        else $error("Sensor register write lost.");

    // Automatic calibration exactly when the trim is zero.
    AST_AUTO_CAL: assert property (SENSOR_AUTO_CAL == (SENSOR_MANUAL_TRIM == RSC_RESET_TRIM))
        else $error("Calibration mode does not match the trim.");

    // Set-default clears the writable fields.
    AST_SET_DEFAULT: assert property (cmd_default |=> (SENSOR_MANUAL_TRIM == RSC_RESET_TRIM)
        && (SENSOR_GAIN_SELECT == RSC_RESET_GSEL) && !CHANNEL_SELECT && SENSOR_AUTO_CAL)
        else $error("Set-default left a field set.");

    // A write to the strength register leaves the peaks alone.
    AST_RO_STRENGTH: assert property (wr_now && (idx == RSC_IDX_STRENGTH) && !peak_clear && !LEVEL_VALID
        |=> $stable(amp_channel_peak_strength) && $stable(phase_channel_peak_strength))
        else $error("Write disturbed a read-only register.");

    // Each request gets one ack in the next cycle.
    AST_BUS_ANSWER: assert property (rsc_seq_req |=> rsc_seq_answer)
        else $error("Bus answer not one cycle after the request.");

    // The phase peak never falls without a clear.
    AST_PH_PEAK_HOLD: assert property (!peak_clear
        |=> phase_channel_peak_strength >= $past(phase_channel_peak_strength))
        else $error("Phase peak fell without a clear.");

    // A larger amplitude code is taken into the peak.
    AST_AMP_PEAK_LOAD: assert property (LEVEL_VALID && !peak_clear && (AMP_LEVEL_CODE <= RSC_CODE_MAX)
        && (AMP_LEVEL_CODE > amp_channel_peak_strength) |=> amp_channel_peak_strength == $past(AMP_LEVEL_CODE))
        else $error("Amplitude peak missed a larger code.");

    // A clear that meets a legal measurement restarts both holds at that code.
    sequence rsc_seq_clear_meas;
        peak_clear && LEVEL_VALID && (AMP_LEVEL_CODE <= RSC_CODE_MAX) && (PHASE_LEVEL_CODE <= RSC_CODE_MAX);
    endsequence
    AST_CLEAR_RESTART: assert property (rsc_seq_clear_meas
        |=> (amp_channel_peak_strength == $past(AMP_LEVEL_CODE))
        && (phase_channel_peak_strength == $past(PHASE_LEVEL_CODE)))
        else $error("Clear with a measurement lost the new code.");

    // A code above the top of the scale is held as the top code.
    AST_AMP_CLAMP: assert property (LEVEL_VALID && (AMP_LEVEL_CODE > RSC_CODE_MAX)
        |=> amp_channel_peak_strength == RSC_CODE_MAX)
        else $error("Amplitude code above the top was not clamped.");

    // The same clamp holds on the phase channel.
    AST_PH_CLAMP: assert property (LEVEL_VALID && (PHASE_LEVEL_CODE > RSC_CODE_MAX)
        |=> phase_channel_peak_strength == RSC_CODE_MAX)
        else $error("Phase code above the top was not clamped.");

    // No phase code above thirteen appears.
    AST_PH_CODE_LIMIT: assert property (phase_channel_peak_strength <= RSC_CODE_MAX)
        else $error("Phase strength code above the top code.");

    // A write to the channel select register lands at the ack edge.
    sequence rsc_seq_chsel_write;
        wr_now && (idx == RSC_IDX_CHSEL);
    endsequence
    AST_CHSEL_WRITE: assert property (rsc_seq_chsel_write |=> CHANNEL_SELECT == $past(DAT_I[RSC_CHSEL_BIT]))
        else $error("Channel select write lost.");

    // The channel select only moves on its own write or on set-default.
    AST_CHSEL_HOLD: assert property (!(wr_now && (idx == RSC_IDX_CHSEL)) && !cmd_default
        |=> $stable(CHANNEL_SELECT))
        else $error("Channel select changed without a write.");

    // The sensor fields only move on their own write or on set-default.
    AST_TRIM_HOLD: assert property (!(wr_now && (idx == RSC_IDX_CAP)) && !cmd_default
        |=> $stable(SENSOR_MANUAL_TRIM) && $stable(SENSOR_GAIN_SELECT))
        else $error("Sensor fields changed without a write.");

    // A write to a read-only index leaves the writable fields alone.
    AST_RO_NO_SIDE: assert property (wr_now && ((idx == RSC_IDX_STRENGTH) || (idx == RSC_IDX_GAIN))
        |=> $stable(SENSOR_MANUAL_TRIM) && $stable(SENSOR_GAIN_SELECT) && $stable(CHANNEL_SELECT))
        else $error("Write to a read-only register changed a field.");

    // Set-default with no measurement empties both peaks.
    AST_DEFAULT_PEAKS: assert property (cmd_default && !LEVEL_VALID
        |=> (amp_channel_peak_strength == RSC_RESET_CODE) && (phase_channel_peak_strength == RSC_RESET_CODE))
        else $error("Set-default left a peak set.");

    // Set-default clears the gain display for one cycle.
    AST_DEFAULT_GAIN: assert property (cmd_default
        |=> (st_q.amp_gain == RSC_RESET_CODE) && (st_q.ph_gain == RSC_RESET_CODE))
        else $error("Set-default left the gain display set.");

    // A read of the strength index answers with both peaks.
    AST_READ_STRENGTH: assert property (req && !ACK_O && (idx == RSC_IDX_STRENGTH)
        |=> DAT_O[7:0] == {$past(amp_channel_peak_strength), $past(phase_channel_peak_strength)})
        else $error("Strength read data wrong.");

    // A read of the gain index answers with both gain fields.
    AST_READ_GAIN: assert property (req && !ACK_O && (idx == RSC_IDX_GAIN)
        |=> DAT_O[7:0] == {$past(st_q.amp_gain), $past(st_q.ph_gain)})
        else $error("Gain read data wrong.");

    // A read of the sensor index answers with trim and gain select.
    AST_READ_CAP: assert property (req && !ACK_O && (idx == RSC_IDX_CAP)
        |=> DAT_O[7:0] == {$past(SENSOR_MANUAL_TRIM), $past(SENSOR_GAIN_SELECT)})
        else $error("Sensor read data wrong.");

    // Ack lasts one cycle only, even under a held request.
    AST_ACK_PULSE: assert property (ACK_O |=> !ACK_O)
        else $error("Ack longer than one cycle.");

    // No ack appears without a request.
    AST_ACK_NO_REQ: assert property (!req |=> !ACK_O)
        else $error("Ack without a request.");
endmodule // rsc_top
`default_nettype wire
